// file: pkg/gtc_cfg.svh
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH
// Functional notes
// - inputs held for under one millisecond are filtered and never trigger
// - falling-edge ports fire their function on a high-to-low input change
// - rising-edge ports fire their function on a low-to-high input change
// - edge ports are sampled once per frame and fire at most once per frame
// - level ports follow both transitions; polarity picks the active level
// - active-low level ports hold their function while the input is low
// - active-high level ports hold their function while the input is high
// - other command sources override contact input commands of any trigger type
// - eight ports, each with its own function, trigger type and polarity
// - only ports whose function selects message insertion produce triggers
// - every edge trigger drives a one-second pulse on that port's output

`define GTC_NPORTS 8
`define GTC_ADDR_W 12
`define GTC_CLK_HZ 125000000
`define GTC_MIN_PULSE_MS 1
`define GTC_MIN_PULSE_CYC ((`GTC_MIN_PULSE_MS * `GTC_CLK_HZ + 999) / 1000)
`define GTC_OUT_PULSE_S 1
`define GTC_OUT_PULSE_CYC (`GTC_OUT_PULSE_S * `GTC_CLK_HZ)

`define GTC_ADDR_CTRL 12'h000
`define GTC_ADDR_STATE 12'h004
`define GTC_ADDR_IRQ_STS 12'h008
`define GTC_ADDR_IRQ_MASK 12'h00c

`define GTC_CTRL_FN_LSB 0
`define GTC_CTRL_TRIG_LSB 8
`define GTC_CTRL_POL_LSB 16
`define GTC_STATE_LVL_LSB 0
`define GTC_STATE_ACT_LSB 8
`define GTC_STATE_PULSE_LSB 16
`define GTC_IRQ_EDGE_LSB 0
`define GTC_IRQ_LEVEL_LSB 8

`define GTC_CTRL_RST 24'h000000
`define GTC_IRQ_MASK_RST 16'h0000
`define GTC_PIN_IDLE_RST 1'b1
`endif

// file: pkg/gtc_pkg.sv
`include "gtc_cfg.svh"

package gtc_pkg;
    typedef logic [`GTC_NPORTS-1:0] gtc_vec_t;

    // per-port settings, one bit per port in each field
    typedef struct packed {
        gtc_vec_t pol;
        gtc_vec_t edge_sel;
        gtc_vec_t fn_en;
    } gtc_port_cfg_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`GTC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } gtc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } gtc_apb_rsp_t;

    typedef enum logic [1:0] {
        GTC_PL_IDLE = 2'b01,
        GTC_PL_ON = 2'b10
    } gtc_pl_state_t;
endpackage

// file: design/gtc_filter.sv
`include "gtc_cfg.svh"

module gtc_filter #(
    parameter int unsigned MIN_CYC = `GTC_MIN_PULSE_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // raw pin
    input wire logic i_pin,
    // filtered level
    output logic o_level
);
    localparam int CW = $clog2(MIN_CYC + 1);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic [CW-1:0] cnt_r;

    // three stages; only the second and third are compared
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= `GTC_PIN_IDLE_RST;
            s2_r <= `GTC_PIN_IDLE_RST;
            s3_r <= `GTC_PIN_IDLE_RST;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a new level must hold for the full dwell before it is accepted
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_r <= `GTC_PIN_IDLE_RST;
            cnt_r <= '0;
        end else if (s2_r == s3_r && s3_r != lvl_r) begin
            if (cnt_r == CW'(MIN_CYC - 1)) begin
                lvl_r <= s3_r;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end else begin
            cnt_r <= '0;
        end
    end

    assign o_level = lvl_r;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_min_dwell;
        $changed(lvl_r) |-> $past(cnt_r) == CW'(MIN_CYC - 1);
    endproperty
    a_min_dwell: assert property (p_min_dwell) else $error("level accepted early");

    property p_sync_agree;
        $changed(lvl_r) |-> ($past(s2_r) == $past(s3_r)) && (lvl_r == $past(s3_r));
    endproperty
    a_sync_agree: assert property (p_sync_agree) else $error("level not from synced pin");
endmodule

// file: design/gtc_pulse.sv
`include "gtc_cfg.svh"

module gtc_pulse #(
    parameter int unsigned LEN = `GTC_OUT_PULSE_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // trigger
    input wire logic i_start,
    // pulse output
    output logic o_pulse
);
    import gtc_pkg::*;

    localparam int CW = $clog2(LEN + 1);

    gtc_pl_state_t state_r;
    logic [CW-1:0] cnt_r;

    // a new trigger while running restarts the full second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= GTC_PL_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                GTC_PL_IDLE: begin
                    if (i_start) begin
                        state_r <= GTC_PL_ON;
                        cnt_r <= '0;
                    end
                end
                GTC_PL_ON: begin
                    if (i_start) begin
                        cnt_r <= '0;
                    end else if (cnt_r == CW'(LEN - 1)) begin
                        state_r <= GTC_PL_IDLE;
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= GTC_PL_IDLE;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    assign o_pulse = (state_r == GTC_PL_ON);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_pulse_start;
        i_start |=> o_pulse && (cnt_r == '0);
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse not started");

    property p_pulse_len;
        $fell(o_pulse) |-> ($past(cnt_r) == CW'(LEN - 1)) && !$past(i_start);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
endmodule

// file: design/gtc_conditioner.sv
`include "gtc_cfg.svh"

module gtc_conditioner #(
    parameter int unsigned NPORTS = `GTC_NPORTS,
    parameter int unsigned MIN_CYC = `GTC_MIN_PULSE_CYC,
    parameter int unsigned PULSE_CYC = `GTC_OUT_PULSE_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register bus
    input wire gtc_pkg::gtc_apb_req_t i_apb,
    output gtc_pkg::gtc_apb_rsp_t o_apb,
    // contact pins, raw electrical level
    input wire logic [NPORTS-1:0] i_contact_input_port,
    // video timing and command arbitration
    input wire logic i_frame_strobe,
    input wire logic i_override,
    // message triggers
    output logic [NPORTS-1:0] o_msg_trig,
    output logic [NPORTS-1:0] o_msg_level,
    // per-port one-second outputs
    output logic [NPORTS-1:0] o_pulse,
    // interrupt
    output logic o_irq
);
    import gtc_pkg::*;

    gtc_port_cfg_t cfg_r;
    logic [NPORTS-1:0] filt;
    logic [NPORTS-1:0] samp_r;
    logic [NPORTS-1:0] trig_r;
    logic [NPORTS-1:0] level_r;
    logic [NPORTS-1:0] rise_c;
    logic [NPORTS-1:0] fall_c;
    logic [NPORTS-1:0] fire_c;
    logic [NPORTS-1:0] lvl_cfg_c;
    logic [NPORTS-1:0] level_nxt;
    logic [NPORTS-1:0] fall_req_c;
    logic [NPORTS-1:0] rise_req_c;
    logic [2*NPORTS-1:0] sts_r;
    logic [2*NPORTS-1:0] sts_nxt;
    logic [2*NPORTS-1:0] mask_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    logic acc;
    logic wr;
    logic hit;

    // per-port conditioning and output pulse
    for (genvar i = 0; i < NPORTS; i++) begin : g_port
        gtc_filter #(
            .MIN_CYC(MIN_CYC)
        ) u_filt (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_pin(i_contact_input_port[i]),
            .o_level(filt[i])
        );
        gtc_pulse #(
            .LEN(PULSE_CYC)
        ) u_pulse (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_start(trig_r[i]),
            .o_pulse(o_pulse[i])
        );
    end

    // edge detection against the previous frame sample only
    always_comb begin
        rise_c = ~samp_r & filt;
        fall_c = samp_r & ~filt;
        fall_req_c = cfg_r.fn_en & cfg_r.edge_sel & ~cfg_r.pol & fall_c;
        rise_req_c = cfg_r.fn_en & cfg_r.edge_sel & cfg_r.pol & rise_c;
        fire_c = i_frame_strobe ? (fall_req_c | rise_req_c) : '0;
        lvl_cfg_c = cfg_r.fn_en & ~cfg_r.edge_sel;
        level_nxt = lvl_cfg_c & ~(filt ^ cfg_r.pol) & ~{NPORTS{i_override}};
    end

    // bursts inside one frame collapse into a single sample
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            samp_r <= {NPORTS{`GTC_PIN_IDLE_RST}};
        end else if (i_frame_strobe) begin
            samp_r <= filt;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trig_r <= '0;
        end else begin
            trig_r <= fire_c & ~{NPORTS{i_override}};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level_r <= '0;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign o_msg_trig = trig_r;
    assign o_msg_level = level_r;

    // apb slave, zero wait states
    assign acc = i_apb.psel & i_apb.penable;
    assign wr = acc & i_apb.pwrite;
    assign hit = (i_apb.paddr == `GTC_ADDR_CTRL) || (i_apb.paddr == `GTC_ADDR_STATE) ||
                 (i_apb.paddr == `GTC_ADDR_IRQ_STS) || (i_apb.paddr == `GTC_ADDR_IRQ_MASK);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_r <= `GTC_CTRL_RST;
        end else if (wr && i_apb.paddr == `GTC_ADDR_CTRL) begin
            cfg_r.fn_en <= i_apb.pwdata[`GTC_CTRL_FN_LSB +: NPORTS];
            cfg_r.edge_sel <= i_apb.pwdata[`GTC_CTRL_TRIG_LSB +: NPORTS];
            cfg_r.pol <= i_apb.pwdata[`GTC_CTRL_POL_LSB +: NPORTS];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_r <= `GTC_IRQ_MASK_RST;
        end else if (wr && i_apb.paddr == `GTC_ADDR_IRQ_MASK) begin
            mask_r <= i_apb.pwdata[2*NPORTS-1:0];
        end
    end

    // write-one-to-clear; a new event in the same cycle survives the clear
    always_comb begin
        sts_nxt = sts_r;
        if (wr && i_apb.paddr == `GTC_ADDR_IRQ_STS) begin
            sts_nxt = sts_nxt & ~i_apb.pwdata[2*NPORTS-1:0];
        end
        sts_nxt[`GTC_IRQ_EDGE_LSB +: NPORTS] = sts_nxt[`GTC_IRQ_EDGE_LSB +: NPORTS] | trig_r;
        sts_nxt[`GTC_IRQ_LEVEL_LSB +: NPORTS] = sts_nxt[`GTC_IRQ_LEVEL_LSB +: NPORTS] |
                                               (level_r ^ level_nxt);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sts_r <= '0;
        end else begin
            sts_r <= sts_nxt;
        end
    end

    assign o_irq = |(sts_r & mask_r);

    always_comb begin
        rd_mux = '0;
        case (i_apb.paddr)
            `GTC_ADDR_CTRL: begin
                rd_mux[`GTC_CTRL_FN_LSB +: NPORTS] = cfg_r.fn_en;
                rd_mux[`GTC_CTRL_TRIG_LSB +: NPORTS] = cfg_r.edge_sel;
                rd_mux[`GTC_CTRL_POL_LSB +: NPORTS] = cfg_r.pol;
            end
            `GTC_ADDR_STATE: begin
                rd_mux[`GTC_STATE_LVL_LSB +: NPORTS] = filt;
                rd_mux[`GTC_STATE_ACT_LSB +: NPORTS] = level_r;
                rd_mux[`GTC_STATE_PULSE_LSB +: NPORTS] = o_pulse;
            end
            `GTC_ADDR_IRQ_STS: rd_mux[2*NPORTS-1:0] = sts_r;
            `GTC_ADDR_IRQ_MASK: rd_mux[2*NPORTS-1:0] = mask_r;
            default: rd_mux = '0;
        endcase
    end

    // read data captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_r <= '0;
        end else if (i_apb.psel && !i_apb.penable) begin
            prdata_r <= i_apb.pwrite ? 32'h00000000 : rd_mux;
        end
    end

    assign o_apb.pready = 1'b1;
    assign o_apb.pslverr = acc & ~hit;
    assign o_apb.prdata = prdata_r;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_fall_fire;
        (i_frame_strobe && !i_override) |=> ((o_msg_trig & $past(fall_req_c)) == $past(fall_req_c));
    endproperty
    a_fall_fire: assert property (p_fall_fire) else $error("falling edge missed");

    property p_rise_fire;
        (i_frame_strobe && !i_override) |=> ((o_msg_trig & $past(rise_req_c)) == $past(rise_req_c));
    endproperty
    a_rise_fire: assert property (p_rise_fire) else $error("rising edge missed");

    property p_frame_only;
        !i_frame_strobe |=> (o_msg_trig == '0) && $stable(samp_r);
    endproperty
    a_frame_only: assert property (p_frame_only) else $error("edge acted outside frame");

    property p_level_both;
        (!i_override && !$past(i_override) && $stable(cfg_r) &&
         (((filt ^ $past(filt)) & lvl_cfg_c) != '0)) |=> $changed(o_msg_level);
    endproperty
    a_level_both: assert property (p_level_both) else $error("level change ignored");

    property p_active_low;
        !i_override |=> ((o_msg_level & $past(lvl_cfg_c & ~cfg_r.pol)) ==
                         $past(lvl_cfg_c & ~cfg_r.pol & ~filt));
    endproperty
    a_active_low: assert property (p_active_low) else $error("active low wrong");

    property p_active_high;
        !i_override |=> ((o_msg_level & $past(lvl_cfg_c & cfg_r.pol)) ==
                         $past(lvl_cfg_c & cfg_r.pol & filt));
    endproperty
    a_active_high: assert property (p_active_high) else $error("active high wrong");

    property p_override;
        i_override |=> ((o_msg_trig | o_msg_level) == '0);
    endproperty
    a_override: assert property (p_override) else $error("override not honoured");

    property p_fn_gate;
        1'b1 |=> (((o_msg_trig | o_msg_level) & ~$past(cfg_r.fn_en)) == '0);
    endproperty
    a_fn_gate: assert property (p_fn_gate) else $error("disabled port triggered");

    property p_one_fire;
        (o_msg_trig != '0) |=> ((o_msg_trig & $past(o_msg_trig)) == '0);
    endproperty
    a_one_fire: assert property (p_one_fire) else $error("fired twice in a frame");

    property p_frame_samp;
        i_frame_strobe |=> (samp_r == $past(filt));
    endproperty
    a_frame_samp: assert property (p_frame_samp) else $error("sample missed");

    // port settings decide which output a port may drive
    property p_edge_port;
        1'b1 |=> ((o_msg_trig & ~$past(cfg_r.edge_sel)) == '0);
    endproperty
    a_edge_port: assert property (p_edge_port) else $error("level port fired edge");

    property p_level_port;
        1'b1 |=> ((o_msg_level & $past(cfg_r.edge_sel)) == '0);
    endproperty
    a_level_port: assert property (p_level_port) else $error("edge port held level");

    // the one-second output starts only from a delivered trigger
    property p_pulse_go;
        (o_msg_trig != '0) |=> ((o_pulse & $past(o_msg_trig)) == $past(o_msg_trig));
    endproperty
    a_pulse_go: assert property (p_pulse_go) else $error("pulse not started");

    property p_pulse_why;
        1'b1 |=> ((o_pulse & ~$past(o_pulse) & ~$past(o_msg_trig)) == '0);
    endproperty
    a_pulse_why: assert property (p_pulse_why) else $error("pulse without trigger");

    property p_ovr_pulse;
        i_override |=> ##1 ((o_pulse & ~$past(o_pulse)) == '0);
    endproperty
    a_ovr_pulse: assert property (p_ovr_pulse) else $error("pulse under override");

    property p_level_sts;
        1'b1 |-> ((sts_r[`GTC_IRQ_LEVEL_LSB +: NPORTS] & (o_msg_level ^ $past(o_msg_level))) ==
                  (o_msg_level ^ $past(o_msg_level)));
    endproperty
    a_level_sts: assert property (p_level_sts) else $error("level change not flagged");

    // status and bus; an event and its clear in one cycle keep the event
    property p_sts_set;
        (o_msg_trig != '0) |=> ((sts_r[`GTC_IRQ_EDGE_LSB +: NPORTS] & $past(o_msg_trig)) ==
                                $past(o_msg_trig));
    endproperty
    a_sts_set: assert property (p_sts_set) else $error("edge event not flagged");

    property p_mask_wr;
        (wr && i_apb.paddr == `GTC_ADDR_IRQ_MASK) |=>
            (mask_r == $past(i_apb.pwdata[2*NPORTS-1:0]));
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

    property p_setup_nowr;
        (i_apb.psel && !i_apb.penable) |=> $stable(cfg_r) && $stable(mask_r);
    endproperty
    a_setup_nowr: assert property (p_setup_nowr) else $error("write in setup cycle");

    property p_rd_load;
        (i_apb.psel && !i_apb.penable && !i_apb.pwrite) |=> (o_apb.prdata == $past(rd_mux));
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("read data not loaded");

    c_edge_fire: cover property (|o_msg_trig);
    c_level_on: cover property (|o_msg_level);
    c_pulse_on: cover property ($rose(|o_pulse));
    c_irq: cover property ($rose(o_irq));
    c_override: cover property (i_override && i_frame_strobe);
endmodule

// file: test/gtc_contact_model.sv
module gtc_contact_model #(
    parameter int unsigned NPORTS = 8
) (
    // clock
    input wire logic i_clk,
    // contact pins, pulled up
    output logic [NPORTS-1:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NPORTS-1:0] closed_r = '0;
    // open contact goes to the pull-up, closed one shorts to ground
    assign o_pin = ~closed_r;
    // one clean change per call, no bounce, so one pulse per event
    task automatic set_contact(input int p, input logic c);
        @(posedge i_clk);
        closed_r[p] <= c;
    endtask
endmodule

// file: test/gtc_conditioner_test.sv
`include "gtc_cfg.svh"

module gtc_conditioner_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gtc_pkg::*;
    // short counts keep the run small
    localparam int unsigned MIN_CYC = 8;
    localparam int unsigned PULSE_CYC = 20;
    localparam int SETTLE = MIN_CYC + 6;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    gtc_apb_req_t apb_req = '0;
    gtc_apb_rsp_t apb_rsp;
    logic [7:0] pins;
    logic frame_strobe = 1'b0;
    logic override = 1'b0;
    logic [7:0] msg_trig;
    logic [7:0] msg_level;
    logic [7:0] pulse;
    logic irq;
    int num_errors = 0;
    int checked = 0;
    int pulse_cnt = 0;
    int p = 0;
    integer seed = 32'h206b;
    logic [7:0] trig_q[$];
    logic [31:0] rd;
    logic err;

    always #4 i_clk = ~i_clk;

    gtc_conditioner #(.MIN_CYC(MIN_CYC), .PULSE_CYC(PULSE_CYC)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_apb(apb_req), .o_apb(apb_rsp),
        .i_contact_input_port(pins), .i_frame_strobe(frame_strobe),
        .i_override(override), .o_msg_trig(msg_trig), .o_msg_level(msg_level),
        .o_pulse(pulse), .o_irq(irq));

    gtc_contact_model #(.NPORTS(8)) u_contact (.i_clk(i_clk), .o_pin(pins));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // waits on pready rather than assuming the zero-wait answer
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge i_clk);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= wdata;
        @(posedge i_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (apb_rsp.pready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask

    task automatic strobe();
        @(posedge i_clk);
        frame_strobe <= 1'b1;
        @(posedge i_clk);
        frame_strobe <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic press(input logic c);
        u_contact.set_contact(p, c);
        repeat (SETTLE) @(posedge i_clk);
    endtask

    // every trigger seen is matched against the oldest expectation
    always @(negedge i_clk) begin
        if (pulse[p] === 1'b1) pulse_cnt++;
        if (i_rst_n && msg_trig !== 8'h00) begin
            if (trig_q.size() == 0) check(msg_trig, 8'h00);
            else check(msg_trig, trig_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdchk(`GTC_ADDR_CTRL, 32'h0);
        rdchk(`GTC_ADDR_IRQ_MASK, 32'h0);
        rdchk(`GTC_ADDR_STATE, 32'h0000ff);
        apb(1'b1, `GTC_ADDR_STATE, 32'hffffff);
        rdchk(12'h010, 32'h0);
        check(err, 1'b1);
        rdchk(`GTC_ADDR_STATE, 32'h0000ff);
        $display("register test done");

        apb(1'b1, `GTC_ADDR_CTRL, 32'h00ffff);
        p = $unsigned($random(seed)) % 8;
        u_contact.set_contact(p, 1'b1);
        repeat (1 + $unsigned($random(seed)) % (MIN_CYC - 3)) @(posedge i_clk);
        press(1'b0);
        strobe();
        rdchk(`GTC_ADDR_STATE, 32'h0000ff);
        pulse_cnt = 0;
        press(1'b1);
        trig_q.push_back(8'h01 << p);
        strobe();
        strobe();
        repeat (PULSE_CYC) @(posedge i_clk);
        check(pulse_cnt, PULSE_CYC);
        rdchk(`GTC_ADDR_IRQ_STS, 32'h1 << p);
        apb(1'b1, `GTC_ADDR_IRQ_MASK, 32'h1 << p);
        @(negedge i_clk);
        check(irq, 1'b1);
        apb(1'b1, `GTC_ADDR_IRQ_STS, 32'h1 << p);
        @(negedge i_clk);
        check(irq, 1'b0);
        apb(1'b1, `GTC_ADDR_IRQ_MASK, 32'h0);
        press(1'b0);
        strobe();
        apb(1'b1, `GTC_ADDR_CTRL, 32'hffffff & ~(32'h1 << p));
        press(1'b1);
        strobe();
        press(1'b0);
        strobe();
        apb(1'b1, `GTC_ADDR_CTRL, 32'hffffff);
        press(1'b1);
        strobe();
        override <= 1'b1;
        press(1'b0);
        strobe();
        override <= 1'b0;
        press(1'b1);
        strobe();
        trig_q.push_back(8'h01 << p);
        press(1'b0);
        strobe();
        check(32'(trig_q.size()), 32'h0);
        $display("edge test done");

        apb(1'b1, `GTC_ADDR_CTRL, 32'h0000ff);
        check(msg_level, 8'h00);
        press(1'b1);
        check(msg_level, 8'h01 << p);
        override <= 1'b1;
        repeat (2) @(posedge i_clk);
        check(msg_level, 8'h00);
        override <= 1'b0;
        repeat (2) @(posedge i_clk);
        check(msg_level, 8'h01 << p);
        press(1'b0);
        check(msg_level, 8'h00);
        apb(1'b1, `GTC_ADDR_CTRL, 32'hff00ff);
        repeat (2) @(posedge i_clk);
        check(msg_level, 8'hff);
        rdchk(`GTC_ADDR_STATE, 32'h00ffff);
        $display("level test done");
        report_and_stop();
    end
endmodule
